// File: hw/sbp_map.vh
// Register map, field positions, reset values and timing constants of the serial byte port.
`ifndef SBP_MAP_VH
`define SBP_MAP_VH
`define SBP_ADDR_W 16
`define SBP_CTRL_OFS 16'hC0E0
`define SBP_FLAGS_OFS 16'hC0E2
`define SBP_BYTE_OFS 16'hC0E4
`define SBP_IRQ_STAT_OFS 16'hC0E6
`define SBP_IRQ_CLR_OFS 16'hC0E8
`define SBP_IRQ_EN_OFS 16'hC0EA
`define SBP_CTRL_RESET 5'h07
`define SBP_CTRL_EN_BIT 0
`define SBP_CTRL_BAUD_HI 3
`define SBP_CTRL_BAUD_LO 1
`define SBP_CTRL_PRESCALE_BIT 4
`define SBP_FLAG_TX_FULL_BIT 0
`define SBP_FLAG_RX_FULL_BIT 1
`define SBP_IRQ_TX_EMPTY_BIT 0
`define SBP_IRQ_RX_FULL_BIT 1
`define SBP_REF_CLK_HZ 48000000
`define SBP_CORE_CLK_HZ 250000000
`define SBP_BASE_BAUD 115200
`define SBP_PRESCALE_DIV 8
`define SBP_DIV_W 19
`endif

// File: hw/sbp_baud_gen.v
// Baud tick generator: one tick per bit time, periods counted in 250 MHz core clock cycles from the 115200 base rate.
`timescale 1ns/1ns
`include "sbp_map.vh"
module sbp_baud_gen (
  core_clk,
  rst_n,
  clk_en,
  restart,
  baud_sel,
  prescale_by_eight,
  bit_tick,
  half_tick
);
  input wire core_clk;
  input wire rst_n;
  input wire clk_en;
  input wire restart;
  input wire [2:0] baud_sel;
  input wire prescale_by_eight;
  output reg bit_tick;
  output reg half_tick;

  localparam [`SBP_DIV_W-1:0] DIV_ONE = {{(`SBP_DIV_W-1){1'b0}}, 1'b1};

  reg [`SBP_DIV_W-1:0] cnt_q;
  wire [`SBP_DIV_W-1:0] period;

  // Rates are 115200 divided by 1, 2, 3, 4, 6, 8, 12 or 16, optionally by eight more.
  // The slowest prescaled rate needs a period above 16 bits, hence the wider counter.
  function [`SBP_DIV_W-1:0] bit_period;
    input [2:0] sel;
    input pre;
    reg [31:0] cycles;
    reg [31:0] div;
    begin
      case (sel)
        3'h0: div = 32'h1;
        3'h1: div = 32'h2;
        3'h2: div = 32'h3;
        3'h3: div = 32'h4;
        3'h4: div = 32'h6;
        3'h5: div = 32'h8;
        3'h6: div = 32'hC;
        default: div = 32'h10;
      endcase
      cycles = (`SBP_CORE_CLK_HZ / `SBP_BASE_BAUD) * div;
      if (pre) begin
        cycles = cycles * `SBP_PRESCALE_DIV;
      end
      bit_period = cycles[`SBP_DIV_W-1:0];
    end
  endfunction

  assign period = bit_period(baud_sel, prescale_by_eight);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= {`SBP_DIV_W{1'b0}};
      bit_tick <= 1'b0;
      half_tick <= 1'b0;
    end else if (clk_en) begin
      bit_tick <= 1'b0;
      half_tick <= 1'b0;
      if (restart || cnt_q == period - DIV_ONE) begin
        cnt_q <= {`SBP_DIV_W{1'b0}};
        bit_tick <= !restart;
      end else begin
        cnt_q <= cnt_q + DIV_ONE;
        half_tick <= (cnt_q == {1'b0, period[`SBP_DIV_W-1:1]});
      end
    end
  end
endmodule // sbp_baud_gen

// File: hw/sbp_uart.v
// Serial byte port: register slave, transmitter, receiver, pin sharing and interrupt logic.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "sbp_map.vh"
module sbp_uart (
  core_clk,
  rst_n,
  clk_en,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  irq_rx_full,
  irq_tx_empty,
  irq,
  shared_receive_pin,
  shared_transmit_pin_o,
  shared_transmit_pin_oe,
  gpio_owned_by_uart
);
  input wire core_clk;
  input wire rst_n;
  input wire clk_en;
  input wire [`SBP_ADDR_W-1:0] reg_addr;
  input wire [15:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [15:0] reg_rdata;
  output reg irq_rx_full;
  output reg irq_tx_empty;
  output reg irq;
  input wire shared_receive_pin;
  output reg shared_transmit_pin_o;
  output reg shared_transmit_pin_oe;
  output reg gpio_owned_by_uart;

  localparam TX_IDLE = 2'h0;
  localparam TX_START = 2'h1;
  localparam TX_DATA = 2'h2;
  localparam TX_STOP = 2'h3;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;

  reg [4:0] ctrl_q;
  reg tx_full_q;
  reg rx_full_q;
  reg [7:0] rx_byte_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_en_q;
  reg [1:0] tx_state_q;
  reg [7:0] tx_shift_q;
  reg [2:0] tx_bit_q;
  reg [1:0] rx_state_q;
  reg [7:0] rx_shift_q;
  reg [2:0] rx_bit_q;
  reg rx_meta_q;
  reg rx_sync_q;
  reg tx_done;
  reg rx_done;

  wire uart_on;
  wire wr_ctrl;
  wire wr_byte;
  wire wr_irq_clr;
  wire wr_irq_en;
  wire rd_byte;
  wire tx_bit_tick;
  wire rx_bit_tick;
  wire rx_half_tick;
  wire tx_restart;
  wire rx_restart;
  wire [1:0] irq_event;

  function hit;
    input [`SBP_ADDR_W-1:0] addr;
    input [`SBP_ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign uart_on = ctrl_q[`SBP_CTRL_EN_BIT];
  assign wr_ctrl = reg_wr && hit(reg_addr, `SBP_CTRL_OFS);
  // Writes to the status offset decode to nothing, so neither flag can be touched by software.
  assign wr_byte = reg_wr && hit(reg_addr, `SBP_BYTE_OFS);
  assign wr_irq_clr = reg_wr && hit(reg_addr, `SBP_IRQ_CLR_OFS);
  assign wr_irq_en = reg_wr && hit(reg_addr, `SBP_IRQ_EN_OFS);
  assign rd_byte = reg_rd && hit(reg_addr, `SBP_BYTE_OFS);
  assign tx_restart = (tx_state_q == TX_IDLE);
  assign rx_restart = (rx_state_q == RX_IDLE);

  sbp_baud_gen u_tx_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(tx_restart),
    .baud_sel(ctrl_q[`SBP_CTRL_BAUD_HI:`SBP_CTRL_BAUD_LO]),
    .prescale_by_eight(ctrl_q[`SBP_CTRL_PRESCALE_BIT]),
    .bit_tick(tx_bit_tick),
    .half_tick()
  );

  sbp_baud_gen u_rx_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .restart(rx_restart),
    .baud_sel(ctrl_q[`SBP_CTRL_BAUD_HI:`SBP_CTRL_BAUD_LO]),
    .prescale_by_eight(ctrl_q[`SBP_CTRL_PRESCALE_BIT]),
    .bit_tick(rx_bit_tick),
    .half_tick(rx_half_tick)
  );

  // Control register; reserved bits are not stored and read back as zero.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= `SBP_CTRL_RESET;
    end else if (clk_en && wr_ctrl) begin
      ctrl_q <= reg_wdata[4:0];
    end
  end

  // Transmitter. A write while busy is dropped: software must wait for transmit-full to fall.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_full_q <= 1'b0;
      tx_done <= 1'b0;
    end else if (clk_en) begin
      tx_done <= 1'b0;
      if (!uart_on) begin
        tx_state_q <= TX_IDLE;
        tx_full_q <= 1'b0;
      end else begin
        case (tx_state_q)
          TX_IDLE: begin
            if (wr_byte) begin
              tx_shift_q <= reg_wdata[7:0];
              tx_full_q <= 1'b1;
              tx_state_q <= TX_START;
            end
          end
          TX_START: begin
            if (tx_bit_tick) begin
              tx_state_q <= TX_DATA;
              tx_bit_q <= 3'h0;
            end
          end
          TX_DATA: begin
            if (tx_bit_tick) begin
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
              if (tx_bit_q == 3'h7) begin
                tx_state_q <= TX_STOP;
              end
            end
          end
          TX_STOP: begin
            if (tx_bit_tick) begin
              tx_state_q <= TX_IDLE;
              tx_full_q <= 1'b0;
              tx_done <= 1'b1;
            end
          end
          default: tx_state_q <= TX_IDLE;
        endcase
      end
    end
  end

  // Two-flop synchroniser on the receive pin.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else if (clk_en) begin
      rx_meta_q <= shared_receive_pin;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Receiver: half-bit check of start, then centre sampling from a restarted bit timer.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_shift_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_done <= 1'b0;
    end else if (clk_en) begin
      rx_done <= 1'b0;
      if (!uart_on) begin
        rx_state_q <= RX_IDLE;
      end else begin
        case (rx_state_q)
          RX_IDLE: begin
            if (!rx_sync_q) begin
              rx_state_q <= RX_START;
            end
          end
          RX_START: begin
            if (rx_half_tick) begin
              rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
              rx_bit_q <= 3'h0;
            end
          end
          RX_DATA: begin
            if (rx_half_tick) begin
              rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (rx_half_tick) begin
              rx_state_q <= RX_IDLE;
              rx_done <= rx_sync_q;
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Receive buffer; a new byte arriving in the cycle of a read wins and keeps the flag set.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_full_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else if (clk_en) begin
      if (rx_done) begin
        rx_byte_q <= rx_shift_q;
        rx_full_q <= 1'b1;
      end else if (rd_byte) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  assign irq_event = {rx_done, tx_done};

  // Sticky interrupt status; a new event beats a simultaneous clear.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
      irq_en_q <= 2'h0;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? reg_wdata[1:0] : 2'h0)) | irq_event;
      if (wr_irq_en) begin
        irq_en_q <= reg_wdata[1:0];
      end
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          `SBP_CTRL_OFS: reg_rdata <= {11'h000, ctrl_q};
          `SBP_FLAGS_OFS: reg_rdata <= {14'h0000, rx_full_q, tx_full_q};
          `SBP_BYTE_OFS: reg_rdata <= {8'h00, rx_byte_q};
          `SBP_IRQ_STAT_OFS: reg_rdata <= {14'h0000, irq_stat_q};
          `SBP_IRQ_EN_OFS: reg_rdata <= {14'h0000, irq_en_q};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Registered outputs; irq_rx_full and irq_tx_empty are levels that follow the flags, while irq follows the sticky status.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      irq_rx_full <= 1'b0;
      irq_tx_empty <= 1'b0;
      irq <= 1'b0;
      shared_transmit_pin_o <= 1'b1;
      shared_transmit_pin_oe <= 1'b0;
      gpio_owned_by_uart <= 1'b0;
    end else if (clk_en) begin
      irq_rx_full <= uart_on && irq_en_q[`SBP_IRQ_RX_FULL_BIT] && rx_full_q;
      irq_tx_empty <= uart_on && irq_en_q[`SBP_IRQ_TX_EMPTY_BIT] && !tx_full_q;
      irq <= |(irq_stat_q & irq_en_q);
      shared_transmit_pin_o <= (tx_state_q == TX_START) ? 1'b0 :
                               (tx_state_q == TX_DATA) ? tx_shift_q[0] : 1'b1;
      shared_transmit_pin_oe <= uart_on;
      gpio_owned_by_uart <= uart_on;
    end
  end
endmodule // sbp_uart

// File: tb/sbp_uart_assertions.sv
// Port assertions for the serial byte port.
`timescale 1ns/1ns
`include "sbp_map.vh"
module sbp_uart_assertions (
  input wire core_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [`SBP_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire irq_rx_full,
  input wire irq_tx_empty,
  input wire irq,
  input wire shared_receive_pin,
  input wire shared_transmit_pin_o,
  input wire shared_transmit_pin_oe,
  input wire gpio_owned_by_uart
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctrl_wr(on);
    reg_wr && reg_addr == `SBP_CTRL_OFS && reg_wdata[0] == on;
  endsequence
  // A write right behind another may meet a busy sender, so only lone writes are judged.
  sequence s_idle_byte_wr;
    reg_wr && reg_addr == `SBP_BYTE_OFS && irq_tx_empty && !$past(reg_wr);
  endsequence
  sequence s_start_fall;
    $fell(shared_transmit_pin_o) && shared_transmit_pin_oe;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("rdata outside answer");
  a_reserved_read_zero: assert property (reg_rdata[15:8] == 8'h00)
    else $error("reserved bits set");
  a_pin_enable_owner: assert property (shared_transmit_pin_oe == gpio_owned_by_uart)
    else $error("enable differs from owner");
  a_disable_release: assert property (
    s_ctrl_wr(1'b0) |-> ##2 !shared_transmit_pin_oe && !irq_rx_full && !irq_tx_empty)
    else $error("pins kept after disable");
  a_enable_claims: assert property (s_ctrl_wr(1'b1) |-> ##2 gpio_owned_by_uart)
    else $error("pins not taken");
  a_rx_irq_owner: assert property (irq_rx_full |-> gpio_owned_by_uart)
    else $error("rx irq while off");
  a_write_starts_tx: assert property (s_idle_byte_wr |-> ##2 !shared_transmit_pin_o)
    else $error("no start bit");
  a_start_bit_hold: assert property (
    s_start_fall |=> (!shared_transmit_pin_o || !shared_transmit_pin_oe) [*8])
    else $error("start bit too short");
endmodule // sbp_uart_assertions
bind sbp_uart sbp_uart_assertions u_sbp_uart_assertions (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq_rx_full, .irq_tx_empty, .irq, .shared_receive_pin, .shared_transmit_pin_o,
  .shared_transmit_pin_oe, .gpio_owned_by_uart);

// File: tb/sbp_remote_uart.sv
// Remote serial transceiver model facing the port's pins.
`timescale 1ns/1ns
module sbp_remote_uart (
  input wire core_clk,
  input wire line_in,
  output logic line_out
);
  int bit_cyc = 2170;
  int got_count = 0;
  logic [7:0] got_byte;
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 10; i++) begin
      line_out <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : v[i - 1];
      repeat (bit_cyc) @(posedge core_clk);
    end
  endtask
  // Mid-bit sampling tolerates the small rate error of the port's divider.
  always begin
    @(negedge line_in);
    repeat (bit_cyc / 2) @(posedge core_clk);
    if (line_in === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge core_clk);
        got_byte[i] = line_in;
      end
      repeat (bit_cyc) @(posedge core_clk);
      if (line_in === 1'b1) got_count++;
    end
  end
endmodule // sbp_remote_uart

// File: tb/sbp_uart_tb.sv
// Bench for the serial byte port.
`timescale 1ns/1ns
`include "sbp_map.vh"
module sbp_uart_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq_rx_full, irq_tx_empty, irq, shared_transmit_pin_o, shared_transmit_pin_oe, gpio_owned_by_uart;
  wire rx_line;
  // The board pulls the pin up once the port lets go of it.
  wire tx_line = shared_transmit_pin_oe ? shared_transmit_pin_o : 1'b1;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] b;
  initial forever #2 core_clk = ~core_clk;
  sbp_uart u_sbp_uart (.core_clk, .rst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq_rx_full, .irq_tx_empty, .irq, .shared_receive_pin(rx_line), .shared_transmit_pin_o,
    .shared_transmit_pin_oe, .gpio_owned_by_uart);
  sbp_remote_uart u_sbp_remote_uart (.core_clk, .line_in(tx_line), .line_out(rx_line));
  function automatic int exp_bit(input int sel, input bit pre);
    int div [8] = '{1, 2, 3, 4, 6, 8, 12, 16};
    return 250000000 / 115200 * div[sel] * (pre ? 8 : 1);
  endfunction
  task automatic ck(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    ck(reg_rdata, exp, what);
    @(posedge core_clk);
  endtask
  task automatic wait_irq(input bit rx);
    n = 0;
    while ((rx ? irq_rx_full : irq_tx_empty) !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    ck({15'h0000, rx ? irq_rx_full : irq_tx_empty}, 16'h0001, "irq level");
    @(posedge core_clk);
  endtask
  task automatic rate(input int sel, input bit pre);
    int lo;
    int ex;
    ex = exp_bit(sel, pre);
    lo = 0;
    n = 0;
    wr(`SBP_CTRL_OFS, {11'h000, pre, sel[2:0], 1'b1});
    wr(`SBP_BYTE_OFS, {8'h00, 8'($urandom) | 8'h01});
    while (tx_line !== 1'b0 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    while (tx_line === 1'b0 && lo < 200000) begin
      @(negedge core_clk);
      lo++;
    end
    ck({15'h0000, lo > ex - ex / 100 && lo < ex + ex / 100}, 16'h0001, "bit time");
    @(posedge core_clk);
    wr(`SBP_CTRL_OFS, 16'h0000);
    @(negedge core_clk);
    ck({15'h0000, shared_transmit_pin_oe | gpio_owned_by_uart}, 16'h0000, "pins held");
    @(posedge core_clk);
    rd(`SBP_FLAGS_OFS, 16'h0000, "abort");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 100000) begin
      err_total++;
      $display("BAD t=%0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h6EBB));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`SBP_CTRL_OFS, 16'h0007, "ctrl reset");
    rd(`SBP_FLAGS_OFS, 16'h0000, "flags reset");
    rd(`SBP_BYTE_OFS, 16'h0000, "data reset");
    wr(`SBP_FLAGS_OFS, 16'h0003);
    rd(`SBP_FLAGS_OFS, 16'h0000, "flags written");
    rd(16'hC0F0, 16'h0000, "unmapped");
    $display("done registers");
    wr(`SBP_CTRL_OFS, 16'h0001);
    wr(`SBP_IRQ_EN_OFS, 16'h0003);
    b = 8'($urandom);
    wr(`SBP_BYTE_OFS, {8'h00, b});
    rd(`SBP_FLAGS_OFS, 16'h0001, "tx busy");
    wait_irq(1'b0);
    rd(`SBP_FLAGS_OFS, 16'h0000, "tx done");
    ck({8'h00, u_sbp_remote_uart.got_byte}, {8'h00, b}, "line byte");
    ck(16'(u_sbp_remote_uart.got_count), 16'h0001, "frames");
    rd(`SBP_IRQ_STAT_OFS, 16'h0001, "tx event");
    @(negedge core_clk);
    ck({14'h0000, irq, irq_tx_empty}, 16'h0003, "tx irq");
    @(posedge core_clk);
    wr(`SBP_IRQ_EN_OFS, 16'h0000);
    @(negedge core_clk);
    ck({14'h0000, irq, irq_tx_empty}, 16'h0000, "masked");
    @(posedge core_clk);
    wr(`SBP_IRQ_EN_OFS, 16'h0003);
    wr(`SBP_IRQ_CLR_OFS, 16'h0003);
    rd(`SBP_IRQ_STAT_OFS, 16'h0000, "cleared");
    $display("done transmit");
    b = 8'($urandom);
    u_sbp_remote_uart.send_byte(b);
    wait_irq(1'b1);
    rd(`SBP_FLAGS_OFS, 16'h0002, "rx full");
    rd(`SBP_BYTE_OFS, {8'h00, b}, "rx byte");
    rd(`SBP_FLAGS_OFS, 16'h0000, "rx read");
    rd(`SBP_IRQ_STAT_OFS, 16'h0002, "rx event");
    $display("done receive");
    rate(4, 1'b0);
    rate(0, 1'b1);
    $display("done rates");
    complete_run();
  end
endmodule // sbp_uart_tb
